// >>> rtl/tick_timer_defines.vh
`ifndef TICK_TIMER_DEFINES_VH
`define TICK_TIMER_DEFINES_VH

// ****************************************
// Register byte addresses
// ****************************************
`define TICK_ADDR_CTRL 32'he000e010
`define TICK_ADDR_RELOAD 32'he000e014
`define TICK_ADDR_CURRENT 32'he000e018
`define TICK_ADDR_CALIB 32'he000e01c

// ****************************************
// Control and status fields
// ****************************************
`define TICK_BIT_ENABLE 0
`define TICK_BIT_INT_ENABLE 1
`define TICK_BIT_CLK_SELECT 2
`define TICK_BIT_ZERO_FLAG 16
`define TICK_CTRL_RESET 1'b0
`define TICK_CLK_SELECT_VALUE 1'b1

// ****************************************
// Counter layout
// ****************************************
`define TICK_WIDTH 24
`define TICK_MSB 23
`define TICK_ZERO 24'h000000

// ****************************************
// Calibration word
// ****************************************
`define TICK_CALIB_VALUE 32'h800a71ff

`endif

// >>> rtl/tick_freeze_sync.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Two-stage synchroniser for the freeze inputs
// ****************************************
module tick_freeze_sync (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Asynchronous level in, synchronised level out
	input wire async_in,
	output reg sync_out
);

	reg meta;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule

`default_nettype wire

// >>> rtl/tick_down_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "tick_timer_defines.vh"

// ****************************************
// 24-bit down counter core
// ****************************************
module tick_down_counter (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Control
	input wire run,
	input wire clear,
	input wire [23:0] reload,
	// Status
	output reg [23:0] count,
	output reg zero_step
);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= `TICK_ZERO;
			zero_step <= 1'b0;
		end else begin
			zero_step <= 1'b0;
			if (clear) begin
				count <= `TICK_ZERO;
			end else if (run) begin
				if (count == `TICK_ZERO) begin
					count <= reload;
				end else begin
					count <= count - 24'h000001;
					zero_step <= (count == 24'h000001);
				end
			end
		end
	end

endmodule

`default_nettype wire

// >>> rtl/system_tick_timer.v
// Overview of operation
// - A 24-bit down counter whose arrival at zero can request an interrupt.
// - The counter always runs from the system clock; no slower reference.
// - Control bit 2, clock select, is read-only and always reads 1.
// - Enabled, count down to zero, reload next edge, then keep counting.
// - Stepping to zero sets the zero-reached flag in control bit 16.
// - Reading the control register clears the zero-reached flag.
// - Interrupt enable bit 1 raises the interrupt on each zero arrival.
// - Counter holds its value while the processor is debug-halted.
// - Counter stops while its clock is gated in low power.
// - Reload gets no defined hardware start content; the current value resets to zero.
// - A full-word write to the current value register clears the counter.
// - Control bit 0 enables the counter when 1, disables when 0.
// - A current value write also clears the zero-reached flag.
// - Reload register holds bits 23:0; upper bits read zero.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tick_timer_defines.vh"

module system_tick_timer (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Freeze requests from outside the clock domain
	input wire debug_halt,
	input wire clock_gated,
	// Tick interrupt request
	output reg tick_irq
);

	// ****************************************
	// Freeze synchronisers
	// ****************************************
	wire halt_sync;
	wire gate_sync;

	tick_freeze_sync u_halt_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(debug_halt),
		.sync_out(halt_sync)
	);

	tick_freeze_sync u_gate_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(clock_gated),
		.sync_out(gate_sync)
	);

	// ****************************************
	// Control state
	// ****************************************
	reg enable;
	reg int_enable;
	reg zero_flag;
	reg [23:0] reload;
	wire [23:0] count;
	wire zero_step;

	// Setup phase decode; the access phase answers one cycle later
	wire setup = psel & ~penable;
	wire access = psel & penable & pready;
	wire hit_ctrl = (paddr == `TICK_ADDR_CTRL);
	wire hit_reload = (paddr == `TICK_ADDR_RELOAD);
	wire hit_current = (paddr == `TICK_ADDR_CURRENT);
	wire hit_calib = (paddr == `TICK_ADDR_CALIB);
	wire hit_any = hit_ctrl | hit_reload | hit_current | hit_calib;
	// Partial-lane writes are not honoured; only full words take effect
	wire full_word = (pstrb == 4'hf);
	wire wr = access & pwrite & full_word;
	wire wr_ctrl = wr & hit_ctrl;
	wire wr_reload = wr & hit_reload;
	wire wr_current = wr & hit_current;
	wire rd_ctrl = access & ~pwrite & hit_ctrl;

	// Frozen when debug-halted or when the clock is gated off
	wire run = enable & ~halt_sync & ~gate_sync;

	// Counter runs straight off pclk, no prescale exists
	tick_down_counter u_counter (
		.pclk(pclk),
		.presetn(presetn),
		.run(run),
		.clear(wr_current),
		.reload(reload),
		.count(count),
		.zero_step(zero_step)
	);

	// ****************************************
	// Registers
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable <= `TICK_CTRL_RESET;
			int_enable <= `TICK_CTRL_RESET;
		end else if (wr_ctrl) begin
			enable <= pwdata[`TICK_BIT_ENABLE];
			int_enable <= pwdata[`TICK_BIT_INT_ENABLE];
		end
	end

	// Reload has no reset: its content is undefined until written
	always @(posedge pclk) begin
		if (wr_reload) begin
			reload <= pwdata[`TICK_MSB:0];
		end
	end

	// Set wins over a clearing read or write in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_flag <= `TICK_CTRL_RESET;
		end else if (zero_step) begin
			zero_flag <= 1'b1;
		end else if (rd_ctrl | wr_current) begin
			zero_flag <= 1'b0;
		end
	end

	// One-cycle request per zero arrival
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_irq <= 1'b0;
		end else begin
			tick_irq <= zero_step & int_enable;
		end
	end

	// ****************************************
	// APB answer
	// ****************************************
	reg [31:0] next_prdata;

	always @* begin
		next_prdata = 32'h00000000;
		if (hit_ctrl) begin
			next_prdata[`TICK_BIT_ENABLE] = enable;
			next_prdata[`TICK_BIT_INT_ENABLE] = int_enable;
			next_prdata[`TICK_BIT_CLK_SELECT] = `TICK_CLK_SELECT_VALUE;
			// A step at the setup edge must show, since the access edge clears it
			next_prdata[`TICK_BIT_ZERO_FLAG] = zero_flag | zero_step;
		end else if (hit_reload) begin
			next_prdata[`TICK_MSB:0] = reload;
		end else if (hit_current) begin
			next_prdata[`TICK_MSB:0] = count;
		end else if (hit_calib) begin
			next_prdata = `TICK_CALIB_VALUE;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (setup) begin
			pready <= 1'b1;
			pslverr <= ~hit_any | (pwrite & ~full_word);
			prdata <= pwrite ? 32'h00000000 : next_prdata;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
	end

endmodule

`default_nettype wire

// >>> verif/tick_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "tick_timer_defines.vh"
module tick_timer_properties (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Freeze and interrupt
	input wire logic debug_halt,
	input wire logic clock_gated,
	input wire logic tick_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd_ok = pready && !pwrite && !pslverr;
	wire setup = psel && !penable;
	answer_a: assert property (setup |=> pready) else $error("no answer");
	ready_once_a: assert property (pready |=> !pready) else $error("long ready");
	strb_err_a: assert property (setup && pwrite && pstrb != 4'hf |=> pslverr)
		else $error("no strobe error");
	clk_sel_a: assert property (rd_ok && paddr == `TICK_ADDR_CTRL |-> prdata[2]
		&& prdata[31:17] == 15'h0 && prdata[15:3] == 13'h0) else $error("bad control");
	reload_resv_a: assert property (rd_ok && paddr == `TICK_ADDR_RELOAD
		|-> prdata[31:24] == 8'h0) else $error("bad reload");
	cur_resv_a: assert property (rd_ok && paddr == `TICK_ADDR_CURRENT
		|-> prdata[31:24] == 8'h0) else $error("bad current");
	irq_pulse_a: assert property (tick_irq |=> !tick_irq) else $error("long irq");
	halt_freeze_a: assert property (debug_halt [*6] |-> !tick_irq)
		else $error("irq in halt");
	gate_freeze_a: assert property (clock_gated [*6] |-> !tick_irq)
		else $error("irq when gated");
endmodule
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tick_timer_defines.vh"
module tb;
	localparam logic [31:0] ctl = `TICK_ADDR_CTRL;
	localparam logic [31:0] rld = `TICK_ADDR_RELOAD;
	localparam logic [31:0] cur = `TICK_ADDR_CURRENT;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic debug_halt = 0, clock_gated = 0, pready, pslverr, tick_irq;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd, keep;
	logic [3:0] pstrb = 4'hf;
	integer num_errors = 0, n_compared = 0, n_irq, i;
	system_tick_timer u_dut (.*);
	initial forever #2.5 pclk = ~pclk;
	// ****************************************
	// Tasks
	// ****************************************
	task chk(input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task xfer(input logic w, input logic [31:0] a, d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1;
		// Hold the request until pready is seen high; the watchdog ends a hang
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task ticks(input integer c);
		n_irq = 0;
		repeat (c) begin
			@(posedge pclk);
			n_irq += tick_irq;
		end
	endtask
	task report_and_stop;
		if (num_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		xfer(0, ctl, 0, 4'hf);
		chk(rd, 32'h4);
		xfer(1, rld, 32'hff000005, 4'hf);
		xfer(1, rld, 32'h7, 4'h3);
		chk({31'h0, er}, 1);
		xfer(0, rld, 0, 4'hf);
		chk(rd, 32'h5);
		xfer(1, cur, 32'h1234, 4'hf);
		xfer(1, ctl, 3, 4'hf);
		ticks(60);
		chk(n_irq, 9);
		xfer(1, ctl, 0, 4'hf);
		xfer(0, cur, 0, 4'hf);
		keep = rd;
		xfer(0, ctl, 0, 4'hf);
		chk(rd, 32'h10004);
		xfer(0, ctl, 0, 4'hf);
		chk(rd, 32'h4);
		xfer(0, cur, 0, 4'hf);
		chk(rd, keep);
		xfer(1, ctl, 1, 4'hf);
		ticks(20);
		chk(n_irq, 0);
		xfer(1, ctl, 0, 4'hf);
		xfer(1, cur, 32'h5a, 4'hf);
		xfer(0, ctl, 0, 4'hf);
		chk(rd, 32'h4);
		xfer(0, cur, 0, 4'hf);
		chk(rd, 0);
		for (i = 0; i < 2; i++) begin
			@(posedge pclk);
			{clock_gated, debug_halt} <= 2'b01 << i;
			xfer(1, ctl, 3, 4'hf);
			ticks(30);
			chk(n_irq, 0);
			{clock_gated, debug_halt} <= 2'b00;
			ticks(30);
			chk(n_irq, 4);
			xfer(1, ctl, 0, 4'hf);
			xfer(1, cur, 0, 4'hf);
		end
		xfer(0, 32'he000e020, 0, 4'hf);
		chk({rd[30:0], er}, 1);
		report_and_stop;
	end
	initial begin
		#20000;
		num_errors++;
		report_and_stop;
	end
endmodule
bind system_tick_timer tick_timer_properties u_props (.*);
`default_nettype wire
